/* File: verilog/cfg_regs_pkg.sv */
/*
   Package for the memory, clock and DMA configuration register bank.
   Holds indices, field positions, reset values and decoded field types.
   Assumes one 10 MHz system clock and an index/data port in front.
*/
package cfg_regs_pkg;

   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_BANK_LOW = 8'h02;
   localparam logic [7:0] IDX_BANK_HIGH = 8'h03;
   localparam logic [7:0] IDX_DRAM_CTL = 8'h04;
   localparam logic [7:0] IDX_SLOW_REF = 8'h05;
   localparam logic [7:0] IDX_CLOCK_CTL = 8'h06;
   localparam logic [7:0] IDX_MISC = 8'h07;
   localparam logic [7:0] IDX_DMA_CTL = 8'h08;
   localparam int NUM_REGS = 7;
   localparam logic [2:0] FIRST_IDX = 3'h2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_BANK_LOW = 8'h8A;
   localparam logic [7:0] RST_BANK_HIGH = 8'h88;
   localparam logic [7:0] RST_DRAM_CTL = 8'h00;
   localparam logic [7:0] RST_SLOW_REF = 8'h00;
   localparam logic [7:0] RST_CLOCK_CTL = 8'h1B;
   localparam logic [7:0] RST_MISC = 8'h00;
   localparam logic [7:0] RST_DMA_CTL = 8'h38;

   // ------------------------------------------------------------
   // Field positions and write masks
   // ------------------------------------------------------------
   localparam int POS_PAIRING = 4;
   localparam int POS_TIMEOUT_OFF = 3;
   localparam int POS_EXT_PARITY = 7;
   localparam int POS_STRENGTH = 1;
   localparam int POS_PAGE = 0;
   localparam int POS_SLOW_DIV = 5;
   localparam int POS_TURBO = 4;
   localparam int POS_REF_SEL = 0;
   localparam int POS_FAST_EN = 7;
   localparam int POS_BUS_OSC = 2;
   localparam int POS_TAG9 = 6;
   localparam int POS_WE_TIME = 5;
   localparam int POS_FAST_RC = 4;
   localparam int POS_CACHE_EN = 3;
   localparam int POS_PARITY_N = 2;
   localparam int POS_EXT_DMA = 7;
   localparam int POS_PAGE_PTR = 6;
   localparam int POS_BYTE_WS = 4;
   localparam int POS_WORD_WS = 2;
   localparam int POS_DMA_CLK = 1;
   localparam int POS_MEMR = 0;
   localparam logic [7:0] WMASK_SLOW_REF = 8'hEF;
   localparam logic [7:0] WMASK_CLOCK_CTL = 8'hFB;
   localparam logic [7:0] WMASK_MISC = 8'hBF;

   // ------------------------------------------------------------
   // Timing: refresh intervals in ns, and counts at 10 MHz
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int REF_FAST_NS = 15625;
   localparam int REF_SLOW_NS = 125000;
   localparam int REF_FAST_CYC = REF_FAST_NS / CLK_PERIOD_NS;
   localparam int REF_SLOW_CYC = REF_SLOW_NS / CLK_PERIOD_NS;
   // Bus clock sense: edges after reset until the synchronised pins hold
   // real levels, and the count value at which the catch is done.
   localparam logic [1:0] SENSE_READY = 2'h2;
   localparam logic [1:0] SENSE_DONE = 2'h3;

   typedef enum logic [1:0] {
      BANK_NONE = 2'b00,
      BANK_256K = 2'b01,
      BANK_1M = 2'b10,
      BANK_4M = 2'b11
   } bank_kind_type;

   typedef struct packed {
      bank_kind_type kind;
      logic double_sided;
   } bank_cfg_type;

   typedef struct packed {
      bank_cfg_type [3:0] bank;
      logic [2:0] bank_pairing_select;
      logic pair01;
      logic pair03;
      logic pair12;
      logic pair23;
      logic page_access_select;
      logic [1:0] dram_output_strength;
      logic drive_addr_24ma;
      logic drive_ras_24ma;
      logic drive_cas_24ma;
      logic row_strobe_timeout_off;
      logic external_parity_error_enable;
      logic [3:0] slow_speed_divider;
      logic refresh_interval_select;
      logic [13:0] refresh_period_cycles;
      logic fast_region_freq_change_enable;
      logic parity_gen_check_enable_n;
      logic cache_controller_enable;
      logic fast_internal_cycle;
      logic write_strobe_early_off;
      logic extended_dma_addr_enable;
      logic page_register_bank_pointer;
      logic [2:0] byte_dma_wait_states;
      logic [2:0] word_dma_wait_states;
      logic dma_clock_select;
      logic dma_memory_read_timing;
   } cfg_out_type;

endpackage : cfg_regs_pkg

/* File: verilog/cfg_reg_store.sv */
/*
   Seven-byte register store for the configuration bank.
   Read data come out of a register one cycle after the index.
   Assumes synchronous writes from the single system clock domain.
*/
module cfg_reg_store (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [2:0] wr_slot,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_slot,
   output logic [7:0] rd_data,
   output logic [55:0] all_regs
);
   import cfg_regs_pkg::*;

   typedef struct packed {
      logic [6:0][7:0] mem;
      logic [7:0] rd;
   } store_state_type;

   store_state_type s_q;
   store_state_type s_d;

   always_comb begin
      s_d = s_q;
      if (wr_en && wr_slot < 3'(NUM_REGS)) begin
         s_d.mem[wr_slot] = wr_data;
      end
      s_d.rd = (rd_slot < 3'(NUM_REGS)) ? s_q.mem[rd_slot] : 8'h00;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q.mem <= {RST_DMA_CTL, RST_MISC, RST_CLOCK_CTL, RST_SLOW_REF,
                     RST_DRAM_CTL, RST_BANK_HIGH, RST_BANK_LOW};
         s_q.rd <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd;
   assign all_regs = s_q.mem;

endmodule : cfg_reg_store

/* File: verilog/cfg_regs.sv */
/*
   Memory, clock and DMA configuration register bank, indices 02h-08h.
   Software reaches it through an index/data port: index_wr latches an
   index, data_wr writes the selected register, data_rd returns it two
   cycles later on rd_data. Decoded settings go to the memory, refresh,
   and DMA engines, which report idle so new values take effect only
   between their cycles.
   Assumes the index/data strobes come from logic on sys_clk, while the
   turbo, bus clock, oscillator-present and tag inputs are board pins
   that may change at any time and are therefore synchronised here.
   The bus clock sense is caught once per reset and does not follow the
   pin afterwards.
*/
// Notes on behaviour
// - Bank type codes: 00 none, 01 256K, 10 1M, 11 4M.
// - Per-bank side flag: 0 single, 1 double sided module.
// - Interleave pairing code 000..110 selects pairs; 111 unused.
// - Page mode bit 0 enables page mode; 1 restricts to bursts.
// - Two-bit drive field sets 12 or 24 mA per output group.
// - Row strobe time-out disable bit and external parity pin enable.
// - Slow speed field divides clock: 000 full, up to 111 by eight.
// - Turbo bit is read-only pin level; writes ignored.
// - Refresh bit selects 15.625 us or 125 us interval.
// - Fast-bus bit allows clock change in fast bus region.
// - Bus oscillator sense reads 0 slow, 1 fast clock.
// - At reset sense is 0 with oscillator, else sampled pin.
// - Extended DMA address bit enables extended address generation.
// - Page pointer bit routes page register accesses lower or upper.
// - Byte DMA wait states: 00 two, 01 four, 1x three.
// - Word DMA wait states: 00 two, 01 four, 1x three.
// - DMA clock bit: 0 system clock halved, 1 undivided.
// - Memory read timing bit: 1 asserts strobe one DMA clock early.
module cfg_regs (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic index_wr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic turbo_pin,
   input wire logic bus_oscillator_pin,
   input wire logic osc_present,
   input wire logic ninth_tag_pin_level,
   input wire logic mem_idle,
   input wire logic refresh_idle,
   input wire logic dma_idle,
   output cfg_regs_pkg::cfg_out_type cfg
);
   import cfg_regs_pkg::*;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Wait-state code to count; both codes with the high bit set mean three.
   function automatic logic [2:0] wait_states(input logic [1:0] code);
      case (code)
         2'b00: wait_states = 3'h2;
         2'b01: wait_states = 3'h4;
         default: wait_states = 3'h3;
      endcase
   endfunction : wait_states

   // True for the indices that this bank answers.
   function automatic logic in_bank(input logic [7:0] idx);
      in_bank = idx >= IDX_BANK_LOW && idx <= IDX_DMA_CTL;
   endfunction : in_bank

   // A bank field is the type code above the single/double side flag.
   function automatic bank_cfg_type bank_of(input logic [2:0] field);
      bank_of = bank_cfg_type'(field);
   endfunction : bank_of

   // True when the pairing code is one of the two that join this pair.
   function automatic logic pair_hit(input logic [2:0] code,
      input logic [2:0] alone, input logic [2:0] paired);
      pair_hit = code == alone || code == paired;
   endfunction : pair_hit

   // Drive per group, {address, row strobe, column strobe}, 1 for 24 mA.
   // The column strobe is the last to go strong, at code 11 only.
   function automatic logic [2:0] drive_of(input logic [1:0] code);
      drive_of = {code != 2'b00, code[1], code == 2'b11};
   endfunction : drive_of

   // The slow speed code counts up from full speed; the divisor is code+1.
   function automatic logic [3:0] divider_of(input logic [2:0] code);
      divider_of = 4'(code) + 4'h1;
   endfunction : divider_of

   // Refresh interval in clocks; the long one saves standby power at the
   // price of relying on the longer retention of the memory parts.
   function automatic logic [13:0] refresh_count(input logic sel);
      refresh_count = sel ? 14'(REF_SLOW_CYC) : 14'(REF_FAST_CYC);
   endfunction : refresh_count

   // All state of the front end, registered as one word.
   typedef struct packed {
      logic [7:0] index;
      logic [1:0] turbo_sync;
      logic [1:0] osc_sync;
      logic [1:0] tag_sync;
      logic [1:0] oscp_sync;
      logic [1:0] sense_wait;
      logic bus_sense;
      logic rd_pend;
      logic rd_in_bank;
      logic [2:0] rd_slot;
      logic [7:0] rd_data;
      logic rd_valid;
      cfg_out_type cfg;
   } top_state_type;

   top_state_type s_q;
   top_state_type s_d;
   logic [7:0] store_rd;
   logic [6:0][7:0] regs;
   logic store_we;
   logic [2:0] slot;
   logic [7:0] store_wdata;
   logic [7:0] live;

   // Indices outside the bank wrap onto some slot; in_bank keeps such
   // accesses away from the store and the read path answers them with 00h, save the pin bit when they alias slot 3, 4 or 5.
   assign slot = 3'(s_q.index - IDX_BANK_LOW);

   // ------------------------------------------------------------
   // Write path into the register store
   // ------------------------------------------------------------
   // Read-only bits are never stored; merge in live pin levels on read.
   always_comb begin
      store_we = data_wr && in_bank(s_q.index);
      store_wdata = wr_data;
      case (s_q.index)
         IDX_SLOW_REF: store_wdata = wr_data & WMASK_SLOW_REF;
         IDX_CLOCK_CTL: store_wdata = wr_data & WMASK_CLOCK_CTL;
         IDX_MISC: store_wdata = wr_data & WMASK_MISC;
         default: store_wdata = wr_data;
      endcase
   end

   cfg_reg_store u_store (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .wr_en(store_we),
      .wr_slot(slot),
      .wr_data(store_wdata),
      .rd_slot(slot),
      .rd_data(store_rd),
      .all_regs(regs)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // ----------------------------------------------------------
      // Pin synchronisers and bus clock sense
      // ----------------------------------------------------------
      // Each pin passes two flip-flops; only the second is ever read.
      s_d.turbo_sync = {s_q.turbo_sync[0], turbo_pin};
      s_d.osc_sync = {s_q.osc_sync[0], bus_oscillator_pin};
      s_d.tag_sync = {s_q.tag_sync[0], ninth_tag_pin_level};
      s_d.oscp_sync = {s_q.oscp_sync[0], osc_present};
      // The sense is caught once per reset, at the third edge after
      // release: before that the synchronisers still hold their reset
      // zeros, and an earlier catch would read a level never on the pins.
      if (s_q.sense_wait != SENSE_DONE) begin
         s_d.sense_wait = s_q.sense_wait + 2'h1;
      end
      if (s_q.sense_wait == SENSE_READY) begin
         s_d.bus_sense =
            s_q.oscp_sync[1] ? 1'b0 : s_q.osc_sync[1];
      end
      // ----------------------------------------------------------
      // Index latch and read path
      // ----------------------------------------------------------
      if (index_wr) begin
         s_d.index = wr_data;
      end
      s_d.rd_pend = data_rd;
      s_d.rd_in_bank = in_bank(s_q.index);
      s_d.rd_slot = slot;
      s_d.rd_valid = s_q.rd_pend;
      // Pin bits are taken one cycle after the read strobe; a pin that
      // moves inside that gap still shows its older level, two flip-flops behind.
      if (s_q.rd_pend) begin
         live = s_q.rd_in_bank ? store_rd : 8'h00;
         case (s_q.rd_slot)
            3'(IDX_SLOW_REF - IDX_BANK_LOW):
               live[POS_TURBO] = s_q.turbo_sync[1];
            3'(IDX_CLOCK_CTL - IDX_BANK_LOW):
               live[POS_BUS_OSC] = s_q.bus_sense;
            3'(IDX_MISC - IDX_BANK_LOW):
               live[POS_TAG9] = s_q.tag_sync[1];
            default: live = live;
         endcase
         s_d.rd_data = live;
      end else begin
         live = 8'h00;
      end
      // ----------------------------------------------------------
      // Memory controller settings
      // ----------------------------------------------------------
      // Memory settings are held while the memory engine is mid-cycle, so a write that
      // lands during a burst cannot change its timing half way through.
      if (mem_idle) begin
         s_d.cfg.bank[0] = bank_of(regs[0][2:0]);
         s_d.cfg.bank[1] = bank_of(regs[0][6:4]);
         s_d.cfg.bank[2] = bank_of(regs[1][2:0]);
         s_d.cfg.bank[3] = bank_of(regs[1][6:4]);
         s_d.cfg.bank_pairing_select = regs[2][POS_PAIRING +: 3];
         s_d.cfg.pair01 = pair_hit(regs[2][6:4], 3'h1, 3'h5);
         s_d.cfg.pair03 = pair_hit(regs[2][6:4], 3'h2, 3'h6);
         s_d.cfg.pair12 = pair_hit(regs[2][6:4], 3'h3, 3'h6);
         s_d.cfg.pair23 = pair_hit(regs[2][6:4], 3'h4, 3'h5);
         s_d.cfg.page_access_select = regs[2][POS_PAGE];
         s_d.cfg.dram_output_strength = regs[2][POS_STRENGTH +: 2];
         {s_d.cfg.drive_addr_24ma, s_d.cfg.drive_ras_24ma,
            s_d.cfg.drive_cas_24ma} = drive_of(regs[2][2:1]);
         s_d.cfg.row_strobe_timeout_off = regs[2][POS_TIMEOUT_OFF];
         s_d.cfg.external_parity_error_enable = regs[2][POS_EXT_PARITY];
         s_d.cfg.slow_speed_divider =
            divider_of(regs[3][POS_SLOW_DIV +: 3]);
         s_d.cfg.fast_region_freq_change_enable =
            regs[4][POS_FAST_EN];
         s_d.cfg.parity_gen_check_enable_n = regs[5][POS_PARITY_N];
         s_d.cfg.cache_controller_enable = regs[5][POS_CACHE_EN];
         s_d.cfg.fast_internal_cycle = regs[5][POS_FAST_RC];
         s_d.cfg.write_strobe_early_off = regs[5][POS_WE_TIME];
      end
      // ----------------------------------------------------------
      // Refresh settings
      // ----------------------------------------------------------
      // The select travels with its count so the two never disagree.
      if (refresh_idle) begin
         s_d.cfg.refresh_interval_select = regs[3][POS_REF_SEL];
         s_d.cfg.refresh_period_cycles =
            refresh_count(regs[3][POS_REF_SEL]);
      end
      // ----------------------------------------------------------
      // DMA settings
      // ----------------------------------------------------------
      // Wait states leave as counts, so the DMA engine needs no table.
      if (dma_idle) begin
         s_d.cfg.extended_dma_addr_enable = regs[6][POS_EXT_DMA];
         s_d.cfg.page_register_bank_pointer =
            regs[6][POS_PAGE_PTR];
         s_d.cfg.byte_dma_wait_states =
            wait_states(regs[6][POS_BYTE_WS +: 2]);
         s_d.cfg.word_dma_wait_states =
            wait_states(regs[6][POS_WORD_WS +: 2]);
         s_d.cfg.dma_clock_select = regs[6][POS_DMA_CLK];
         s_d.cfg.dma_memory_read_timing = regs[6][POS_MEMR];
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Reset loads the decoded defaults at once, so that the engines see
   // sane settings even before their first idle cycle.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.cfg.bank[0] <= bank_cfg_type'(RST_BANK_LOW[2:0]);
         s_q.cfg.bank[1] <= bank_cfg_type'(RST_BANK_LOW[6:4]);
         s_q.cfg.bank[2] <= bank_cfg_type'(RST_BANK_HIGH[2:0]);
         s_q.cfg.bank[3] <= bank_cfg_type'(RST_BANK_HIGH[6:4]);
         s_q.cfg.slow_speed_divider <= 4'h1;
         s_q.cfg.refresh_period_cycles <= 14'(REF_FAST_CYC);
         s_q.cfg.byte_dma_wait_states <= 3'h3;
         s_q.cfg.word_dma_wait_states <= 3'h3;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from the state register
   // ------------------------------------------------------------
   assign rd_data = s_q.rd_data;
   assign rd_valid = s_q.rd_valid;
   assign cfg = s_q.cfg;

endmodule : cfg_regs

/* File: tb/cfg_regs_sva.sv */
/*
   Concurrent checks for the configuration register bank.
   Assumes it is bound into cfg_regs and sees only that module's ports.
*/
module cfg_regs_sva
   import cfg_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic data_rd,
   input wire logic rd_valid,
   input wire logic dma_idle,
   input wire logic mem_idle,
   input wire logic refresh_idle,
   input wire cfg_out_type cfg
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dflt_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_read_answer: assert property (data_rd |-> ##2 rd_valid)
      else $error("read strobe not answered two cycles later");
   chk_drive_addr: assert property (
      cfg.drive_addr_24ma == (cfg.dram_output_strength != 2'h0))
      else $error("address drive strength wrong");
   chk_drive_ras: assert property (
      cfg.drive_ras_24ma == cfg.dram_output_strength[1])
      else $error("row strobe drive strength wrong");
   chk_drive_cas: assert property (
      cfg.drive_cas_24ma == (cfg.dram_output_strength == 2'h3))
      else $error("column strobe drive strength wrong");
   chk_pair_low: assert property (
      cfg.pair01 == (cfg.bank_pairing_select inside {3'h1, 3'h5}))
      else $error("pairing of banks 0 and 1 wrong");
   chk_pair_cross: assert property (
      cfg.pair03 == (cfg.bank_pairing_select inside {3'h2, 3'h6}))
      else $error("pairing of banks 0 and 3 wrong");
   chk_pair_split: assert property (
      cfg.pair12 == (cfg.bank_pairing_select inside {3'h3, 3'h6}))
      else $error("pairing of banks 1 and 2 wrong");
   chk_mem_frozen: assert property (!mem_idle |=>
      $stable(cfg.bank) && $stable(cfg.page_access_select))
      else $error("memory settings changed while memory busy");
   chk_refresh_frozen: assert property (!refresh_idle |=>
      $stable(cfg.refresh_period_cycles))
      else $error("refresh period changed while refresh busy");
   chk_pair_high: assert property (
      cfg.pair23 == (cfg.bank_pairing_select inside {3'h4, 3'h5}))
      else $error("pairing of banks 2 and 3 wrong");
   chk_slow_div_range: assert property (
      cfg.slow_speed_divider inside {[4'h1:4'h8]})
      else $error("slow speed divider out of range");
   chk_refresh_count: assert property (
      cfg.refresh_period_cycles ==
      (cfg.refresh_interval_select ? 14'h04E2 : 14'h009C))
      else $error("refresh period count wrong");
   chk_dma_frozen: assert property (!dma_idle |=>
      $stable(cfg.dma_clock_select) && $stable(cfg.byte_dma_wait_states))
      else $error("DMA settings changed while DMA busy");
endmodule : cfg_regs_sva

bind cfg_regs cfg_regs_sva u_sva (.sys_clk(sys_clk), .rst_b(rst_b),
   .data_rd(data_rd), .rd_valid(rd_valid), .dma_idle(dma_idle),
   .mem_idle(mem_idle), .refresh_idle(refresh_idle), .cfg(cfg));

/* File: tb/cfg_regs_test.sv */
/*
   Self-checking bench for the configuration register bank.
   Drives the index/data strobes, pins and engine idle flags itself.
*/
module cfg_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   import cfg_regs_pkg::*;

   logic sys_clk = 0, rst_b = 0, index_wr = 0, data_wr = 0, data_rd = 0;
   logic turbo_pin = 0, bus_oscillator_pin = 0, osc_present = 1;
   logic ninth_tag_pin_level = 0, mem_idle = 1, refresh_idle = 1;
   logic dma_idle = 1, rd_valid;
   logic [7:0] wr_data = 8'h00, rd_data;
   cfg_out_type cfg;
   int num_errors = 0, samples_checked = 0;
   localparam logic [7:0] RST_TBL [7] = '{8'h8A, 8'h88, 8'h00, 8'h00,
      8'h1B, 8'h00, 8'h38};
   localparam logic [7:0] ONES_TBL [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hEF,
      8'hFB, 8'hBF, 8'hFF};
   localparam logic [3:0] PAIR_TBL [7] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1,
      4'h9, 4'h6};
   localparam logic [2:0] DRV_TBL [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
   localparam logic [2:0] WS_TBL [4] = '{3'h2, 3'h4, 3'h3, 3'h3};
   wire logic [12:0] flags = {cfg.external_parity_error_enable,
      cfg.row_strobe_timeout_off, cfg.page_access_select,
      cfg.fast_region_freq_change_enable, cfg.parity_gen_check_enable_n,
      cfg.cache_controller_enable, cfg.fast_internal_cycle,
      cfg.write_strobe_early_off, cfg.extended_dma_addr_enable,
      cfg.page_register_bank_pointer, cfg.dma_clock_select,
      cfg.dma_memory_read_timing, cfg.refresh_interval_select};

   always #50 sys_clk = ~sys_clk;

   cfg_regs u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .index_wr(index_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data),
      .rd_data(rd_data), .rd_valid(rd_valid), .turbo_pin(turbo_pin),
      .bus_oscillator_pin(bus_oscillator_pin), .osc_present(osc_present),
      .ninth_tag_pin_level(ninth_tag_pin_level), .mem_idle(mem_idle),
      .refresh_idle(refresh_idle), .dma_idle(dma_idle), .cfg(cfg));

   // ------------------------------------------------------------
   // Access and compare tasks
   // ------------------------------------------------------------
   task automatic check_reg(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check_reg

   task automatic check_field(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check_field

   task automatic put_index(input logic [7:0] idx);
      index_wr <= 1'b1;
      wr_data <= idx;
      @(posedge sys_clk);
      index_wr <= 1'b0;
   endtask : put_index

   // Waits past the store edge and the decode edge before returning.
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
      put_index(idx);
      data_wr <= 1'b1;
      wr_data <= val;
      @(posedge sys_clk);
      data_wr <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : wr_reg

   task automatic read_expect(input logic [7:0] idx, input logic [7:0] exp);
      int n = 0;
      put_index(idx);
      data_rd <= 1'b1;
      @(posedge sys_clk);
      data_rd <= 1'b0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rd_valid !== 1'b1 && n < 6);
      check_field("read valid", 16'h0001, 16'(rd_valid));
      check_reg($sformatf("index %h", idx), exp, rd_data);
   endtask : read_expect

   task automatic apply_reset();
      rst_b <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask : apply_reset

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      int i;
      apply_reset();
      for (i = 0; i < 7; i++) read_expect(8'(i + 2), RST_TBL[i]);
      check_field("flags", 16'h0000, 16'(flags));
      check_field("dma ws", 16'h001B, 16'({cfg.byte_dma_wait_states,
         cfg.word_dma_wait_states}));
      check_field("divider", 16'h0001, 16'(cfg.slow_speed_divider));
      $display("test reset values done");
      for (i = 0; i < 7; i++) wr_reg(8'(i + 2), 8'hFF);
      for (i = 0; i < 7; i++) read_expect(8'(i + 2), ONES_TBL[i]);
      check_field("flags", 16'h1FFF, 16'(flags));
      check_field("banks", 16'h0FFF, 16'(cfg.bank));
      wr_reg(IDX_BANK_LOW, 8'h00);
      wr_reg(IDX_BANK_HIGH, 8'h00);
      check_field("banks", 16'h0000, 16'(cfg.bank));
      turbo_pin <= 1'b1;
      ninth_tag_pin_level <= 1'b1;
      bus_oscillator_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      read_expect(IDX_SLOW_REF, 8'hFF);
      read_expect(IDX_MISC, 8'hFF);
      read_expect(IDX_CLOCK_CTL, 8'hFB);
      $display("test write and pins done");
      wr_reg(8'h09, 8'h55);
      read_expect(8'h09, 8'h00);
      read_expect(8'h01, 8'h00);
      read_expect(IDX_DMA_CTL, 8'hFF);
      $display("test unmapped done");
      for (i = 0; i < 7; i++) begin
         wr_reg(IDX_DRAM_CTL, 8'(i << 4));
         check_field("pairing", 16'(PAIR_TBL[i]), 16'({cfg.pair01,
            cfg.pair03, cfg.pair12, cfg.pair23}));
      end
      for (i = 0; i < 8; i++) begin
         wr_reg(IDX_SLOW_REF, 8'(i << 5));
         check_field("divider", 16'(i + 1), 16'(cfg.slow_speed_divider));
      end
      for (i = 0; i < 4; i++) begin
         wr_reg(IDX_DRAM_CTL, 8'(i << 1));
         check_field("drive", 16'(DRV_TBL[i]), 16'({cfg.drive_addr_24ma,
            cfg.drive_ras_24ma, cfg.drive_cas_24ma}));
         wr_reg(IDX_DMA_CTL, 8'((i << 4) | (i << 2)));
         check_field("dma ws", 16'({WS_TBL[i], WS_TBL[i]}), 16'({
            cfg.byte_dma_wait_states, cfg.word_dma_wait_states}));
      end
      wr_reg(IDX_SLOW_REF, 8'h01);
      check_field("refresh", 16'h04E2, 16'(cfg.refresh_period_cycles));
      $display("test codes done");
      mem_idle <= 1'b0;
      refresh_idle <= 1'b0;
      wr_reg(IDX_DRAM_CTL, 8'h01);
      wr_reg(IDX_SLOW_REF, 8'h00);
      check_field("page", 16'h0000, 16'(cfg.page_access_select));
      check_field("refresh", 16'h04E2,
         16'(cfg.refresh_period_cycles));
      mem_idle <= 1'b1;
      refresh_idle <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check_field("page", 16'h0001, 16'(cfg.page_access_select));
      check_field("refresh", 16'h009C,
         16'(cfg.refresh_period_cycles));
      dma_idle <= 1'b0;
      wr_reg(IDX_DMA_CTL, 8'h02);
      check_field("dma clock", 16'h0000, 16'(cfg.dma_clock_select));
      dma_idle <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check_field("dma clock", 16'h0001, 16'(cfg.dma_clock_select));
      $display("test busy engine done");
      osc_present <= 1'b0;
      apply_reset();
      read_expect(IDX_CLOCK_CTL, 8'h1F);
      $display("test sensed bus clock done");
      print_verdict();
   end

   // A hang in a wait loop ends the run here instead.
   initial begin
      #500000;
      num_errors++;
      print_verdict();
   end
endmodule : cfg_regs_test
